// *** verilog/rtv_map.svh ***
`ifndef RTV_MAP_SVH
`define RTV_MAP_SVH
// ****************************************
// Register offsets (word index on plain port)
// ****************************************
`define RTV_OFF_YEAR        4'h0
`define RTV_OFF_MONTH_DAY_VALUE       4'h1
`define RTV_OFF_WKHR        4'h2
`define RTV_OFF_MINUTES_SECONDS_VALUE      4'h3
`define RTV_OFF_AL_MONTH_DAY_VALUE    4'h4
`define RTV_OFF_AL_WKHR     4'h5
`define RTV_OFF_AL_MINUTES_SECONDS_VALUE   4'h6
`define RTV_OFF_CTRL        4'h7
`define RTV_OFF_CAL         4'h8
`define RTV_OFF_STATUS      4'h9
// ****************************************
// Field masks of writable bits
// ****************************************
`define RTV_MASK_YEAR       16'h00FF
`define RTV_MASK_MONTH_DAY_VALUE      16'h1F3F
`define RTV_MASK_WKHR       16'h073F
`define RTV_MASK_MINUTES_SECONDS_VALUE     16'h7F7F
// ****************************************
// Control and status bit positions
// ****************************************
`define RTV_CTRL_WREN       0
`define RTV_CTRL_EN         1
`define RTV_STAT_HALF       0
// ****************************************
// Timing counts (32.768 kHz tick input)
// ****************************************
`define RTV_TICKS_PER_SEC   15'h7FFF
`define RTV_TICKS_HALF      15'h3FFF
`define RTV_CAL_RESET       8'h00
`endif

// *** verilog/rtv_pkg.sv ***
package rtv_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rtv_bus_req_t;

    typedef struct packed {
        logic [7:0]  year;
        logic [4:0]  month;
        logic [5:0]  day;
        logic [2:0]  weekday_digit;
        logic [5:0]  hour;
        logic [6:0]  min;
        logic [6:0]  sec;
    } rtv_time_t;

    typedef struct packed {
        logic [4:0]  month;
        logic [5:0]  day;
        logic [2:0]  weekday_digit;
        logic [5:0]  hour;
        logic [6:0]  min;
        logic [6:0]  sec;
    } rtv_alarm_t;

    typedef enum logic [1:0] {
        RTV_ADJ_IDLE = 2'b00,
        RTV_ADJ_ADD  = 2'b01,
        RTV_ADJ_SUB  = 2'b11
    } rtv_adj_t;

    typedef struct packed {
        rtv_time_t   tm;
        rtv_alarm_t  al;
        logic        wren;
        logic        en;
        logic [7:0]  cal;
        logic [14:0] div;
        logic        half;
        logic        sec_pulse;
        rtv_adj_t    adj;
        logic [9:0]  adj_cnt;
        logic [15:0] rdata;
    } rtv_state_t;
endpackage

// *** verilog/rtv_core.sv ***
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "rtv_map.svh"
// Contract
// - Year holds tens 7-4, ones 3-0
// - Month tens bit 12, ones 11-8
// - Day tens 5-4, ones 3-0
// - Weekday bits 10-8, values 0-6
// - Hour tens 5-4 up to 2
// - Minute tens 14-12, ones 11-8
// - Second tens 6-4, ones 3-0
// - Unused bits read zero, ignore writes
// - Year writes need write enable set
// - Date, hour, alarm date and alarm hour writes need write enable
// - Time advances by hardware; alarms software-only
// - Alarm fields mirror time layout, reset to zero
// - Signed calibration times four, once per minute
// - Negative removes pulses, positive adds pulses
// - Half-second flag cleared on seconds write
// - 7F adds 508, 80 removes 512
module rtv_core (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Slow clock tick
    input  wire logic                 tick_32k,
    // Register port
    input  wire rtv_pkg::rtv_bus_req_t bus_req,
    output logic [15:0]               bus_rdata,
    // Status
    output logic                      seconds_pulse,
    output logic                      half_second_flag,
    output logic                      clock_write_enable
);
    import rtv_pkg::*;

    rtv_state_t s_q;
    rtv_state_t s_d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] bcd_inc(input logic [3:0] v);
        bcd_inc = (v == 4'h9) ? 4'h0 : v + 4'h1;
    endfunction

    function automatic logic [4:0] days_in(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = (y[4] == 1'b0) ? (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)
                               : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
        case (m)
            5'h02:                      days_in = leap ? 5'h1D : 5'h1C;
            5'h04, 5'h06, 5'h09, 5'h11: days_in = 5'h1E;
            default:                    days_in = 5'h1F;
        endcase
    endfunction

    function automatic logic [5:0] day_bcd(input logic [4:0] d);
        logic [4:0] tens;
        tens = d / 5'd10;
        day_bcd = {tens[1:0], 4'(d % 5'd10)};
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic        tick_sec;
        logic [14:0] limit;
        logic [9:0]  amt;
        s_d = s_q;
        tick_sec = 1'b0;
        s_d.sec_pulse = 1'b0;
        s_d.rdata = 16'h0000;
        amt = {s_q.cal[7], s_q.cal[7], s_q.cal} << 2;
        limit = `RTV_TICKS_PER_SEC;

        if (tick_32k && s_q.en) begin
            // Extra pulse swallowed or inserted per tick of adjust
            if (s_q.adj == RTV_ADJ_SUB && s_q.adj_cnt != 10'h000) begin
                s_d.adj_cnt = s_q.adj_cnt - 10'h001;
            end else begin
                if (s_q.adj == RTV_ADJ_ADD && s_q.adj_cnt != 10'h000) begin
                    s_d.adj_cnt = s_q.adj_cnt - 10'h001;
                end
                if (s_q.div == limit) begin
                    s_d.div = 15'h0000;
                    tick_sec = 1'b1;
                end else begin
                    s_d.div = s_q.div + ((s_q.adj == RTV_ADJ_ADD && s_q.adj_cnt != 10'h000 &&
                                          s_q.div < limit - 15'h0001) ? 15'h0002 : 15'h0001);
                end
            end
            if (s_d.div > `RTV_TICKS_HALF) begin
                s_d.half = 1'b1;
            end else begin
                s_d.half = 1'b0;
            end
        end

        // ****************************************
        // Cascaded BCD time keeping
        // ****************************************
        if (tick_sec) begin
            s_d.sec_pulse = 1'b1;
            s_d.tm.sec[3:0] = bcd_inc(s_q.tm.sec[3:0]);
            if (s_q.tm.sec[3:0] == 4'h9) begin
                s_d.tm.sec[6:4] = (s_q.tm.sec[6:4] == 3'h5) ? 3'h0 : s_q.tm.sec[6:4] + 3'h1;
                if (s_q.tm.sec[6:4] == 3'h5) begin
                    // Minute rollover: load calibration once per minute
                    s_d.adj = (s_q.cal == 8'h00) ? RTV_ADJ_IDLE
                            : (s_q.cal[7] ? RTV_ADJ_SUB : RTV_ADJ_ADD);
                    s_d.adj_cnt = s_q.cal[7] ? 10'(-amt) : amt;
                    s_d.tm.min[3:0] = bcd_inc(s_q.tm.min[3:0]);
                    if (s_q.tm.min[3:0] == 4'h9) begin
                        s_d.tm.min[6:4] = (s_q.tm.min[6:4] == 3'h5) ? 3'h0 : s_q.tm.min[6:4] + 3'h1;
                    end
                    if (s_q.tm.min == 7'h59) begin
                        if (s_q.tm.hour == 6'h23) begin
                            s_d.tm.hour = 6'h00;
                            s_d.tm.weekday_digit = (s_q.tm.weekday_digit == 3'h6) ? 3'h0 : s_q.tm.weekday_digit + 3'h1;
                            if (s_q.tm.day == day_bcd(days_in(s_q.tm.month, s_q.tm.year))) begin
                                s_d.tm.day = 6'h01;
                                if (s_q.tm.month == 5'h12) begin
                                    s_d.tm.month = 5'h01;
                                    s_d.tm.year[3:0] = bcd_inc(s_q.tm.year[3:0]);
                                    if (s_q.tm.year[3:0] == 4'h9) begin
                                        s_d.tm.year[7:4] = bcd_inc(s_q.tm.year[7:4]);
                                    end
                                end else if (s_q.tm.month[3:0] == 4'h9) begin
                                    s_d.tm.month = 5'h10;
                                end else begin
                                    s_d.tm.month[3:0] = s_q.tm.month[3:0] + 4'h1;
                                end
                            end else if (s_q.tm.day[3:0] == 4'h9) begin
                                s_d.tm.day = {s_q.tm.day[5:4] + 2'h1, 4'h0};
                            end else begin
                                s_d.tm.day[3:0] = s_q.tm.day[3:0] + 4'h1;
                            end
                        end else if (s_q.tm.hour[3:0] == 4'h9) begin
                            s_d.tm.hour = {s_q.tm.hour[5:4] + 2'h1, 4'h0};
                        end else begin
                            s_d.tm.hour[3:0] = s_q.tm.hour[3:0] + 4'h1;
                        end
                    end
                end
            end
        end

        // ****************************************
        // Register writes (software wins over tick)
        // ****************************************
        if (bus_req.wr) begin
            if (bus_req.addr == `RTV_OFF_YEAR) begin
                if (s_q.wren) begin
                    s_d.tm.year = bus_req.wdata[7:0];
                end
            end else if (bus_req.addr == `RTV_OFF_MONTH_DAY_VALUE) begin
                if (s_q.wren) begin
                    s_d.tm.month = bus_req.wdata[12:8];
                    s_d.tm.day = bus_req.wdata[5:0];
                end
            end else if (bus_req.addr == `RTV_OFF_WKHR) begin
                if (s_q.wren) begin
                    s_d.tm.weekday_digit = bus_req.wdata[10:8];
                    s_d.tm.hour = bus_req.wdata[5:0];
                end
            end else if (bus_req.addr == `RTV_OFF_MINUTES_SECONDS_VALUE) begin
                s_d.tm.min = bus_req.wdata[14:8];
                s_d.tm.sec = bus_req.wdata[6:0];
                s_d.half = 1'b0;
                s_d.div = 15'h0000;
            end else if (bus_req.addr == `RTV_OFF_AL_MONTH_DAY_VALUE) begin
                if (s_q.wren) begin
                    s_d.al.month = bus_req.wdata[12:8];
                    s_d.al.day = bus_req.wdata[5:0];
                end
            end else if (bus_req.addr == `RTV_OFF_AL_WKHR) begin
                if (s_q.wren) begin
                    s_d.al.weekday_digit = bus_req.wdata[10:8];
                    s_d.al.hour = bus_req.wdata[5:0];
                end
            end else if (bus_req.addr == `RTV_OFF_AL_MINUTES_SECONDS_VALUE) begin
                s_d.al.min = bus_req.wdata[14:8];
                s_d.al.sec = bus_req.wdata[6:0];
            end else if (bus_req.addr == `RTV_OFF_CTRL) begin
                s_d.wren = bus_req.wdata[`RTV_CTRL_WREN];
                if (s_q.wren) begin
                    s_d.en = bus_req.wdata[`RTV_CTRL_EN];
                end
            end else if (bus_req.addr == `RTV_OFF_CAL) begin
                s_d.cal = bus_req.wdata[7:0];
            end
        end

        // ****************************************
        // Register reads, unused bits zero
        // ****************************************
        if (bus_req.rd) begin
            if (bus_req.addr == `RTV_OFF_YEAR) begin
                s_d.rdata = {8'h00, s_q.tm.year};
            end else if (bus_req.addr == `RTV_OFF_MONTH_DAY_VALUE) begin
                s_d.rdata = {3'h0, s_q.tm.month, 2'h0, s_q.tm.day};
            end else if (bus_req.addr == `RTV_OFF_WKHR) begin
                s_d.rdata = {5'h00, s_q.tm.weekday_digit, 2'h0, s_q.tm.hour};
            end else if (bus_req.addr == `RTV_OFF_MINUTES_SECONDS_VALUE) begin
                s_d.rdata = {1'b0, s_q.tm.min, 1'b0, s_q.tm.sec};
            end else if (bus_req.addr == `RTV_OFF_AL_MONTH_DAY_VALUE) begin
                s_d.rdata = {3'h0, s_q.al.month, 2'h0, s_q.al.day};
            end else if (bus_req.addr == `RTV_OFF_AL_WKHR) begin
                s_d.rdata = {5'h00, s_q.al.weekday_digit, 2'h0, s_q.al.hour};
            end else if (bus_req.addr == `RTV_OFF_AL_MINUTES_SECONDS_VALUE) begin
                s_d.rdata = {1'b0, s_q.al.min, 1'b0, s_q.al.sec};
            end else if (bus_req.addr == `RTV_OFF_CTRL) begin
                s_d.rdata = {14'h0000, s_q.en, s_q.wren};
            end else if (bus_req.addr == `RTV_OFF_CAL) begin
                s_d.rdata = {8'h00, s_q.cal};
            end else if (bus_req.addr == `RTV_OFF_STATUS) begin
                s_d.rdata = {15'h0000, s_q.half};
            end else begin
                s_d.rdata = 16'h0000;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.cal <= `RTV_CAL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata          = s_q.rdata;
    assign seconds_pulse      = s_q.sec_pulse;
    assign half_second_flag   = s_q.half;
    assign clock_write_enable = s_q.wren;
endmodule

// *** test/rtv_core_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checks of the time and alarm block
// ****************************************
module rtv_core_checker (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  reset,
    // Slow clock tick and register port
    input wire logic                  tick_32k,
    input wire rtv_pkg::rtv_bus_req_t bus_req,
    input wire logic [15:0]           bus_rdata,
    // Status
    input wire logic                  seconds_pulse,
    input wire logic                  half_second_flag,
    input wire logic                  clock_write_enable
);
    import rtv_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence rd_at(logic [3:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence sec_wr;
        bus_req.wr && bus_req.addr == 4'h3;
    endsequence
    a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_year_fields: assert property (rd_at(4'h0) |=> bus_rdata[15:8] == 8'h00 && bus_rdata[7:4] <= 4'h9)
        else $error("year read out of layout");
    a_month_day_value_fields: assert property (rd_at(4'h1) |=> (bus_rdata & 16'hE0C0) == 16'h0000 && bus_rdata[11:8] <= 4'h9)
        else $error("month day read out of layout");
    a_wkhr_fields: assert property (rd_at(4'h2) |=> (bus_rdata & 16'hF8C0) == 16'h0000 && bus_rdata[10:8] <= 3'h6)
        else $error("weekday hours read out of layout");
    a_minutes_seconds_value_fields: assert property (rd_at(4'h3) |=> (bus_rdata & 16'h8080) == 16'h0000 && bus_rdata[14:12] <= 3'h5)
        else $error("minutes seconds read out of layout");
    a_alarm_layout: assert property (rd_at(4'h6) |=> (bus_rdata & 16'h8080) == 16'h0000 && bus_rdata[6:4] <= 3'h5)
        else $error("alarm minutes seconds out of layout");
    a_half_cleared: assert property (sec_wr |=> !half_second_flag)
        else $error("half second flag not cleared by seconds write");
    a_pulse_single: assert property (seconds_pulse |=> !seconds_pulse [*8])
        else $error("seconds pulse too long or too close");
    a_wren_load: assert property (bus_req.wr && bus_req.addr == 4'h7 |=> clock_write_enable == $past(bus_req.wdata[0]))
        else $error("write enable not loaded");
    a_wren_hold: assert property (!(bus_req.wr && bus_req.addr == 4'h7) |=> $stable(clock_write_enable))
        else $error("write enable changed without a write");
endmodule

bind rtv_core rtv_core_checker u_chk (.core_clk(core_clk), .reset(reset), .tick_32k(tick_32k), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .seconds_pulse(seconds_pulse), .half_second_flag(half_second_flag),
    .clock_write_enable(clock_write_enable));

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import rtv_pkg::*;
    // ****************************************
    // Signals and tables
    // ****************************************
    logic          core_clk;
    logic          reset;
    logic          tick_32k;
    rtv_bus_req_t  bus_req;
    logic [15:0]   bus_rdata;
    logic          seconds_pulse;
    logic          half_second_flag;
    logic          clock_write_enable;
    int            num_errors;
    int            tests_run;
    int            cyc = 0;
    int            cnt;
    logic [15:0]   tw [7] = '{16'hFF99, 16'hF2F1, 16'hFEE3, 16'hD9D9, 16'hF2F1, 16'hFEE3, 16'hD9D9};
    logic [15:0]   te [7] = '{16'h0099, 16'h1231, 16'h0623, 16'h5959, 16'h1231, 16'h0623, 16'h5959};

    rtv_core dut (.core_clk(core_clk), .reset(reset), .tick_32k(tick_32k), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .seconds_pulse(seconds_pulse), .half_second_flag(half_second_flag),
        .clock_write_enable(clock_write_enable));

    // ****************************************
    // Bus, wait and finish tasks
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK(bus_rdata, e)
    endtask

    task automatic wait_hi(input bit sel);
        int n;
        n = 0;
        while ((sel ? seconds_pulse : half_second_flag) !== 1'b1 && n < 40000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(n < 40000, 1'b1)
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Clock and timeout
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            num_errors++;
            stop_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        tick_32k = 1'b1;
        bus_req = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (i != 3 && i != 6) begin
                wr(i[3:0], tw[i]);
                rc(i[3:0], 16'h0000);
            end
        end
        wr(4'h7, 16'h0001);
        #1;
        `CHK(clock_write_enable, 1'b1)
        for (int i = 0; i < 7; i++) begin
            wr(i[3:0], tw[i]);
            rc(i[3:0], te[i]);
        end
        wr(4'hF, 16'hFFFF);
        rc(4'hF, 16'h0000);
        wr(4'h8, 16'hFF7F);
        rc(4'h8, 16'h007F);
        wr(4'h7, 16'h0003);
        rc(4'h7, 16'h0003);
        wr(4'h3, 16'h0958);
        wait_hi(1'b0);
        rc(4'h9, 16'h0001);
        wr(4'h3, 16'h0959);
        #1;
        `CHK(half_second_flag, 1'b0)
        rc(4'h3, 16'h0959);
        wait_hi(1'b1);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
        end while (seconds_pulse !== 1'b1 && cnt < 40000);
        `CHK(cnt, 32768 - 4 * 127)
        rc(4'h3, 16'h1001);
        rc(4'h6, 16'h5959);
        rc(4'h0, 16'h0099);
        stop_test();
    end
endmodule
